/* common/ppt_pkg.sv */
package ppt_pkg;

  // ****************************************************************
  // Command and response type codes.
  // ****************************************************************
  localparam logic [7:0] PPT_CMD_PLDM_REQ  = 8'h51;
  localparam logic [7:0] PPT_RSP_PLDM_REQ  = 8'hD1;
  localparam logic [7:0] PPT_CMD_EVT_EN    = 8'h55;
  localparam logic [7:0] PPT_RSP_EVT_EN    = 8'hD5;
  localparam logic [7:0] PPT_CMD_QUERY     = 8'h56;
  localparam logic [7:0] PPT_RSP_QUERY     = 8'hD6;
  localparam logic [7:0] PPT_CMD_REPLY     = 8'h57;
  localparam logic [7:0] PPT_RSP_REPLY     = 8'hD7;
  localparam logic [7:0] PPT_RSP_TYPE_BIT  = 8'h80;
  localparam logic [7:0] PPT_EVT_PENDING   = 8'h71;

  // ****************************************************************
  // Response and reason codes.
  // ****************************************************************
  localparam logic [15:0] PPT_RC_OK        = 16'h0000;
  localparam logic [15:0] PPT_RC_UNSUP     = 16'h0001;
  localparam logic [15:0] PPT_RS_NONE      = 16'h0000;
  localparam logic [15:0] PPT_RS_UNKNOWN   = 16'h0003;

  // ****************************************************************
  // Enable field and flag layout.
  // ****************************************************************
  localparam int          PPT_EN_MEDIUM_BIT = 0;
  localparam int          PPT_EN_PEND_BIT   = 1;
  localparam logic [15:0] PPT_EN_KEEP_MASK  = 16'h0003;
  localparam logic [15:0] PPT_EN_RESET      = 16'h0000;
  localparam logic [7:0]  PPT_ID_RESET      = 8'h00;
  localparam logic [7:0]  PPT_CC_RESET      = 8'h00;
  localparam int          PPT_FLAG_PEND_BIT = 0;
  localparam logic [7:0]  PPT_FLAGS_ZERO    = 8'h00;

  // ****************************************************************
  // Request queue shape.
  // ****************************************************************
  localparam int PPT_Q_DEPTH = 4;
  localparam int PPT_Q_AW    = 2;

  typedef struct packed {
    logic        request_flag;
    logic        datagram;
    logic [29:0] body;
  } ppt_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  cmd_type;
    logic        chk_err;
    logic        id_mismatch;
    logic [7:0]  mgmt_ctrl_id;
    logic [15:0] transport_event_enable_field;
    logic [7:0]  compl_code;
    ppt_req_t    msg;
  } ppt_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rsp_type;
    logic [15:0] rsp_code;
    logic [15:0] reason;
    logic        has_msg;
    ppt_req_t    msg;
    logic [7:0]  compl_code;
    logic [7:0]  flags;
  } ppt_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] evt_type;
    logic [7:0] event_target_id;
  } ppt_evt_t;

  typedef struct packed {
    logic       valid;
    ppt_req_t   msg;
    logic [7:0] compl_code;
  } ppt_reply_t;

  localparam ppt_req_t PPT_REQ_ZERO = '0;

endpackage

/* verilog/ppt_req_fifo.sv */
`timescale 1ns/10ps
module ppt_req_fifo
  import ppt_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     ce,
  input  wire logic     in_valid,
  output logic          in_ready,
  input  wire ppt_req_t in_data,
  output logic          out_valid,
  input  wire logic     out_ready,
  output ppt_req_t      out_data
);

  // ****************************************************************
  // Storage and pointers.
  // ****************************************************************
  ppt_req_t                mem [PPT_Q_DEPTH];
  logic [PPT_Q_AW-1:0]     wr_ptr;
  logic [PPT_Q_AW-1:0]     rd_ptr;
  logic [PPT_Q_AW:0]       count;
  wire logic               push;
  wire logic               pop;

  assign in_ready  = (count != PPT_Q_DEPTH[PPT_Q_AW:0]);
  assign out_valid = (count != '0);
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      wr_ptr <= wr_ptr + PPT_Q_AW'(push);
      rd_ptr <= rd_ptr + PPT_Q_AW'(pop);
      count  <= count + (PPT_Q_AW+1)'(push) - (PPT_Q_AW+1)'(pop);
    end
  end

endmodule

/* verilog/ppt_cmd_handler.sv */
// Behaviour
// - Answer every clean encapsulated request with response.
// - Response code reports only transport-layer support.
// - Completion code alone carries encapsulated outcome.
// - Only one outgoing request in flight.
// - Queued requests handled singly, device picks order.
// - Pending-request query command is implemented.
// - Query answer carries message only when pending.
// - Reply answer flag bit zero shows more pending.
// - Reply answer upper seven flag bits zero.
// - Pending event carries its fixed event type.
// - Pending event sent only while enable bit set.
// - Event enable command switches events individually.
// - Stored target identifier goes into every event.
// - Enable bit zero medium change, bit one pending event, upper reserved.
// - New unreported request raises pending event.
// - No event between query and reply answer.
// - Enable command answered with matching response type.
`timescale 1ns/10ps
module ppt_cmd_handler
  import ppt_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     ce,
  input  wire ppt_cmd_t cmd,
  output ppt_rsp_t      rsp,
  output ppt_evt_t      evt,
  output ppt_reply_t    reply,
  input  wire logic     req_valid,
  output logic          req_ready,
  input  wire ppt_req_t req_data,
  output logic          pending,
  output logic [15:0]   event_enable
);

  // ****************************************************************
  // Decoding.
  // ****************************************************************
  logic        have_out;
  ppt_req_t    out_msg;
  logic [7:0]  event_target_id;
  logic        suppress;
  logic        unreported;
  wire logic   q_valid;
  wire ppt_req_t q_data;
  wire logic   take;
  wire logic   is_req;
  wire logic   is_query;
  wire logic   is_reply;
  wire logic   is_en;
  wire logic   known;
  wire logic   q_rd;
  wire logic   q_push;
  wire logic   any_pend;
  wire logic   wants_reply;
  wire logic   fire;
  wire logic   en_pend_bit;
  wire logic [7:0] next_flags;
  ppt_rsp_t    next_rsp;

  assign take     = ce && cmd.valid && !cmd.chk_err && !cmd.id_mismatch;
  assign is_req   = take && (cmd.cmd_type == PPT_CMD_PLDM_REQ);
  assign is_query = take && (cmd.cmd_type == PPT_CMD_QUERY);
  assign is_reply = take && (cmd.cmd_type == PPT_CMD_REPLY);
  assign is_en    = take && (cmd.cmd_type == PPT_CMD_EVT_EN);
  assign known    = is_req || is_query || is_reply || is_en;
  assign any_pend = have_out || q_valid;
  // Only fetch a new request when none is waiting for its reply.
  assign q_rd     = is_query && !have_out;
  assign q_push   = ce && req_valid && req_ready;
  assign wants_reply = q_data.request_flag && !q_data.datagram;
  assign en_pend_bit = event_enable[PPT_EN_PEND_BIT];
  assign fire     = unreported && en_pend_bit && !suppress;
  assign next_flags = {7'b0, q_valid};
  assign pending  = any_pend;

  // ****************************************************************
  // Queue of requests bound for the management controller.
  // ****************************************************************
  // Head of queue goes first; the order is chosen here.
  ppt_req_fifo u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req_data),
    .out_valid (q_valid),
    .out_ready (q_rd),
    .out_data  (q_data)
  );

  // ****************************************************************
  // Response build.
  // ****************************************************************
  always_comb begin
    next_rsp            = '0;
    next_rsp.valid      = take;
    next_rsp.rsp_type   = cmd.cmd_type | PPT_RSP_TYPE_BIT;
    next_rsp.rsp_code   = known ? PPT_RC_OK : PPT_RC_UNSUP;
    next_rsp.reason     = known ? PPT_RS_NONE : PPT_RS_UNKNOWN;
    next_rsp.msg        = PPT_REQ_ZERO;
    if (is_req) begin
      next_rsp.compl_code = cmd.compl_code;
      next_rsp.msg        = cmd.msg;
      next_rsp.has_msg    = 1'b1;
    end
    if (is_query) begin
      next_rsp.has_msg = any_pend;
      if (any_pend) begin
        next_rsp.msg = have_out ? out_msg : q_data;
      end
    end
    if (is_reply) begin
      next_rsp.flags = next_flags;
    end
  end

  // ****************************************************************
  // State.
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp   <= '0;
      evt   <= '0;
      reply <= '0;
    end else if (ce) begin
      rsp                 <= next_rsp;
      evt.valid           <= fire;
      evt.evt_type        <= PPT_EVT_PENDING;
      evt.event_target_id <= event_target_id;
      reply.valid         <= is_reply && have_out;
      reply.msg           <= out_msg;
      reply.compl_code    <= cmd.compl_code;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      have_out <= 1'b0;
      out_msg  <= PPT_REQ_ZERO;
    end else if (q_rd && q_valid) begin
      have_out <= wants_reply;
      out_msg  <= q_data;
    end else if (is_reply) begin
      have_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_enable    <= PPT_EN_RESET;
      event_target_id <= PPT_ID_RESET;
    end else if (is_en) begin
      // Reserved bits are dropped so their sources stay off.
      event_enable    <= cmd.transport_event_enable_field
                         & PPT_EN_KEEP_MASK;
      event_target_id <= cmd.mgmt_ctrl_id;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      suppress   <= 1'b0;
      unreported <= 1'b0;
    end else if (ce) begin
      // Only a fetched request that awaits its reply holds events back.
      if (q_rd && q_valid) begin
        suppress <= wants_reply;
      end else if (is_reply) begin
        suppress <= 1'b0;
      end
      // A new request wins over a report in the same cycle.
      if (q_push) begin
        unreported <= 1'b1;
      end else if (fire || (is_reply && q_valid)) begin
        unreported <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence s_push_armed;
    q_push && en_pend_bit && !suppress && !take && !unreported;
  endsequence

  sequence s_evt_out;
    ##[1:2] evt.valid;
  endsequence

  a_req_answer: assert property (is_req |=> rsp.valid &&
      rsp.rsp_type == PPT_RSP_PLDM_REQ && rsp.rsp_code == PPT_RC_OK)
    else $error("request not answered");
  a_bad_silent: assert property (cmd.valid &&
      (cmd.chk_err || cmd.id_mismatch) |=> !rsp.valid)
    else $error("bad command answered");
  a_cc_pass: assert property (is_req |=>
      rsp.compl_code == $past(cmd.compl_code))
    else $error("completion code altered");
  a_one_fetch: assert property (have_out && !is_reply |=>
      have_out && $stable(out_msg))
    else $error("second request fetched");
  a_query_msg: assert property (is_query |=>
      rsp.has_msg == $past(any_pend) && rsp.rsp_type == PPT_RSP_QUERY)
    else $error("query message presence wrong");
  a_reply_flag: assert property (is_reply |=>
      rsp.flags[PPT_FLAG_PEND_BIT] == $past(q_valid))
    else $error("pending flag wrong");
  a_flag_upper: assert property (rsp.valid |->
      rsp.flags[7:1] == PPT_FLAGS_ZERO[7:1])
    else $error("upper flags not zero");
  a_evt_fields: assert property (evt.valid |->
      evt.evt_type == PPT_EVT_PENDING &&
      evt.event_target_id == $past(event_target_id))
    else $error("event fields wrong");
  a_evt_gate: assert property (evt.valid |->
      $past(en_pend_bit) && !$past(suppress))
    else $error("event sent while gated");
  a_en_store: assert property (is_en |=>
      event_enable == ($past(cmd.transport_event_enable_field)
                       & PPT_EN_KEEP_MASK) &&
      rsp.rsp_type == PPT_RSP_EVT_EN)
    else $error("enable field store wrong");
  a_new_event: assert property (s_push_armed |-> s_evt_out)
    else $error("no event for new request");

endmodule

/* tb/ppt_mc_model.sv */
`timescale 1ns/10ps
// ************************************************
// Management controller side of the command port.
// ************************************************
module ppt_mc_model
  import ppt_pkg::*;
(
  input  wire logic clk,
  output ppt_cmd_t  cmd
);
  initial begin
    cmd = '0;
  end

  // Drives one command for one cycle, then scrambles the idle fields.
  task automatic send(input logic [7:0] typ, input logic [1:0] bad,
                      input logic [15:0] fld, input logic [7:0] id,
                      input logic [7:0] cc, input ppt_req_t m);
    ppt_cmd_t c;
    c = '0;
    c.valid = 1'b1;
    c.cmd_type = typ;
    c.chk_err = bad[0];
    c.id_mismatch = bad[1];
    c.mgmt_ctrl_id = id;
    c.transport_event_enable_field = fld;
    c.compl_code = cc;
    c.msg = m;
    @(negedge clk);
    cmd = c;
    c = ppt_cmd_t'(~c);
    c.valid = 1'b0;
    @(negedge clk);
    cmd = c;
  endtask
endmodule

/* tb/pldm_passthrough_cmd_handler_tb_top.sv */
`timescale 1ns/10ps
module pldm_passthrough_cmd_handler_tb_top;
  import ppt_pkg::*;
  logic        clk = 1'b0;
  logic        rst;
  logic        ce;
  ppt_cmd_t    cmd;
  ppt_rsp_t    rsp;
  ppt_evt_t    evt;
  ppt_reply_t  reply;
  logic        req_valid;
  logic        req_ready;
  ppt_req_t    req_data;
  logic        pending;
  logic [15:0] event_enable;
  int          n_errors = 0;
  int          checked = 0;
  int          n_evt = 0;
  int          cycles = 0;
  int          e0;
  ppt_req_t    q[$];
  ppt_req_t    fly;
  logic        in_fly = 1'b0;
  logic [7:0]  tid = 8'h00;
  logic [1:0]  en = 2'h0;

  always #2 clk = ~clk;

  ppt_mc_model mc_u (.clk(clk), .cmd(cmd));
  ppt_cmd_handler dut_u (
    .clk(clk), .rst(rst), .ce(ce), .cmd(cmd), .rsp(rsp), .evt(evt),
    .reply(reply), .req_valid(req_valid), .req_ready(req_ready),
    .req_data(req_data), .pending(pending), .event_enable(event_enable)
  );

  // ************************************************
  // Checking and closing.
  // ************************************************
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic results();
    $display("mismatches %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  always @(negedge clk) begin
    if (evt.valid === 1'b1) begin
      n_evt++;
      chk({evt.evt_type, evt.event_target_id}, {PPT_EVT_PENDING, tid});
    end
  end

  // ************************************************
  // Stimulus with a behavioural model of the queue.
  // ************************************************
  task automatic push(input logic ok, input logic rq);
    ppt_req_t r;
    r = ppt_req_t'($urandom);
    if (rq) begin
      r.request_flag = 1'b1;
      r.datagram = 1'b0;
    end
    @(negedge clk);
    chk(req_ready, ok);
    req_valid = 1'b1;
    req_data = r;
    if (ok)
      q.push_back(r);
    @(negedge clk);
    req_valid = 1'b0;
    req_data = ppt_req_t'(~r);
  endtask

  task automatic exec(input logic [7:0] op, input logic [15:0] fld);
    ppt_req_t   m;
    ppt_req_t   em;
    logic       eh;
    logic       erv;
    logic [7:0] cc;
    logic [7:0] efl;
    m = ppt_req_t'($urandom);
    cc = 8'($urandom);
    eh = 1'b0;
    em = fly;
    erv = in_fly;
    efl = {7'h00, q.size() != 0};
    if (op == PPT_CMD_QUERY && !in_fly && q.size() != 0) begin
      em = q.pop_front();
      fly = em;
      in_fly = em.request_flag && !em.datagram;
      eh = 1'b1;
    end else if (op == PPT_CMD_QUERY)
      eh = in_fly;
    if (op == PPT_CMD_REPLY)
      in_fly = 1'b0;
    if (op == PPT_CMD_EVT_EN) begin
      en = fld[1:0];
      tid = cc;
    end
    mc_u.send(op, 2'b00, fld, cc, cc, m);
    chk(rsp.valid, 1'b1);
    chk(rsp.rsp_type, op | PPT_RSP_TYPE_BIT);
    chk({rsp.rsp_code, rsp.reason}, (op == 8'h60) ? 32'h0001_0003 : 32'h0000_0000);
    if (op == PPT_CMD_PLDM_REQ)
      chk({rsp.compl_code, rsp.msg}, {cc, m});
    if (op == PPT_CMD_QUERY)
      chk(rsp.has_msg, eh);
    if (op == PPT_CMD_QUERY && eh)
      chk(rsp.msg, em);
    if (op == PPT_CMD_REPLY)
      chk(rsp.flags, efl);
    if (op == PPT_CMD_REPLY)
      chk(reply.valid, erv);
    if (op == PPT_CMD_REPLY && erv)
      chk({reply.msg, reply.compl_code}, {em, cc});
    if (op == PPT_CMD_EVT_EN)
      chk(event_enable, {14'h0000, en});
  endtask

  initial begin
    void'($urandom(86));
    rst = 1'b1;
    ce = 1'b1;
    req_valid = 1'b0;
    req_data = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk({req_ready, pending, event_enable}, 18'h2_0000);
    exec(PPT_CMD_PLDM_REQ, 16'h0000);
    exec(8'h60, 16'h0000);
    mc_u.send(PPT_CMD_PLDM_REQ, 2'b01, 16'h0000, 8'h00, 8'h00, '0);
    chk(rsp.valid, 1'b0);
    mc_u.send(PPT_CMD_PLDM_REQ, 2'b10, 16'h0000, 8'h00, 8'h00, '0);
    chk(rsp.valid, 1'b0);
    ce = 1'b0;
    mc_u.send(PPT_CMD_PLDM_REQ, 2'b00, 16'h0000, 8'h00, 8'h00, '0);
    chk(rsp.valid, 1'b0);
    ce = 1'b1;
    exec(PPT_CMD_EVT_EN, 16'($urandom) | 16'h0002);
    e0 = n_evt;
    push(1'b1, 1'b1);
    repeat (2) @(negedge clk);
    chk(n_evt - e0, 1);
    chk(pending, 1'b1);
    for (int i = 0; i < 3; i++)
      push(1'b1, 1'b0);
    push(1'b0, 1'b0);
    exec(PPT_CMD_QUERY, 16'h0000);
    exec(PPT_CMD_QUERY, 16'h0000);
    e0 = n_evt;
    push(1'b1, 1'b0);
    repeat (3) @(negedge clk);
    chk(n_evt - e0, 0);
    while (in_fly || q.size() != 0) begin
      exec(PPT_CMD_QUERY, 16'h0000);
      if (in_fly)
        exec(PPT_CMD_REPLY, 16'h0000);
    end
    exec(PPT_CMD_QUERY, 16'h0000);
    e0 = n_evt;
    push(1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk(n_evt - e0, 1);
    exec(PPT_CMD_REPLY, 16'h0000);
    exec(PPT_CMD_EVT_EN, 16'hFFFC);
    e0 = n_evt;
    push(1'b1, 1'b0);
    repeat (3) @(negedge clk);
    chk(n_evt - e0, 0);
    results();
  end
endmodule
